// ---- rtl/acw_pkg.sv ----
// Shared constants, register layouts and state types for the converter control block
package acw_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_PRST   = 8'h00;
    localparam logic [7:0] OFF_PCLK   = 8'h04;
    localparam logic [7:0] OFF_MODE0  = 8'h08;
    localparam logic [7:0] OFF_TRIG   = 8'h0C;
    localparam logic [7:0] OFF_REFC   = 8'h10;
    localparam logic [7:0] OFF_UL     = 8'h14;
    localparam logic [7:0] OFF_LL     = 8'h18;
    localparam logic [7:0] OFF_CHSEL  = 8'h1C;
    localparam logic [7:0] OFF_RESULT = 8'h20;
    localparam logic [7:0] OFF_STAT   = 8'h24;
    localparam logic [7:0] OFF_MASK   = 8'h28;

    // Bit positions
    localparam int CONV_RESET_BIT = 5;
    localparam int CONV_CLKEN_BIT = 5;
    localparam int DONE_FLAG_BIT  = 0;

    // Values after reset
    localparam logic [7:0] RST_PRST  = 8'h00;
    localparam logic [7:0] RST_PCLK  = 8'h00;
    localparam logic [7:0] RST_UL    = 8'hFF;
    localparam logic [7:0] RST_LL    = 8'h00;
    localparam logic [7:0] RST_MASK  = 8'h01;
    localparam logic [7:0] RST_ZERO8 = 8'h00;

    // Conversion timing in converter clocks
    localparam logic [4:0] STAB_CLKS = 5'h02;
    localparam logic [4:0] LV1_CLKS  = 5'h13;
    localparam logic [4:0] LV1_SAMP  = 5'h07;
    localparam logic [4:0] LV2_CLKS  = 5'h11;
    localparam logic [4:0] LV2_SAMP  = 5'h05;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [1:0] TMODE_HW_NOWAIT = 2'h2;
    localparam logic [1:0] TIMING_LV2      = 2'h3;
    localparam logic [1:0] PREF_PROHIBITED = 2'h3;

    typedef struct packed {
        logic       conversion_run;
        logic       channel_select_mode;
        logic [2:0] conv_clock_div;
        logic [1:0] conv_timing;
        logic       comparator_enable;
    } acw_mode0_t;

    typedef struct packed {
        logic [1:0] trigger_mode;
        logic       oneshot_select;
        logic [2:0] rsv;
        logic [1:0] hw_trigger_source;
    } acw_trig_t;

    typedef struct packed {
        logic [1:0] pos_reference;
        logic       neg_reference_select;
        logic       rsv4;
        logic       window_check_select;
        logic       snooze_enable;
        logic       rsv1;
        logic       resolution_select;
    } acw_refc_t;

    typedef struct packed {
        logic       internal_source_select;
        logic [1:0] rsv;
        logic [4:0] channel;
    } acw_chsel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_STAB = 2'b10,
        ST_CONV = 2'b11
    } acw_conv_state_t;

    typedef struct packed {
        logic [7:0]      prst;
        logic [7:0]      pclk;
        acw_mode0_t      m0;
        acw_trig_t       trg;
        acw_refc_t       refc;
        logic [7:0]      ul;
        logic [7:0]      ll;
        acw_chsel_t      chs;
        logic [9:0]      result;
        logic [7:0]      stat;
        logic [7:0]      mask;
        logic            aw_v;
        logic [7:0]      aw_a;
        logic            w_v;
        logic [7:0]      w_d;
        logic            w_lane0;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
        acw_conv_state_t st;
        logic [6:0]      div_cnt;
        logic [4:0]      tick_cnt;
        logic [1:0]      scan_idx;
        logic            fad_tick;
        logic            sampling;
        logic            busy;
        logic [5:0]      chan;
        logic            irq;
    } acw_state_t;

    // Converter clock divide ratio per divider code
    function automatic logic [6:0] acw_div(input logic [2:0] code);
        case (code)
            3'h0:    acw_div = 7'h40;
            3'h1:    acw_div = 7'h20;
            3'h2:    acw_div = 7'h10;
            3'h3:    acw_div = 7'h08;
            3'h4:    acw_div = 7'h06;
            3'h5:    acw_div = 7'h05;
            3'h6:    acw_div = 7'h04;
            default: acw_div = 7'h02;
        endcase
    endfunction

endpackage

// ---- rtl/acw_top.sv ----
// Converter control with window compare, reached over AXI4-Lite
// How it works
// - Converter reset bit high holds converter and its registers in reset.
// - Clock-gate bit low stops the converter clock; high supplies it.
// - Channel mode bit: 0 single selected channel, 1 scan through channels.
// - Divider code 0..7 gives converter clock of system clock /64,32,16,8,6,5,4,2.
// - Timing 10: 2+19 clocks, 7 sampling; timing 11: 2+17, 5 sampling.
// - Trigger mode: upper bit 0 software; 10 hardware no-wait; 11 hardware wait.
// - Conversion mode bit: 0 sequential, 1 one-shot.
// - Trigger source: 00 timer ch1, 01 event link, 10 RTC, 11 interval timer.
// - Positive reference: 00 supply, 01 external pin, 10 internal; 11 forbidden.
// - Negative reference bit: 0 ground, 1 external pin shared with input 1.
// - Window check 0: interrupt when lower <= result <= upper.
// - Window check 1: interrupt when result below lower or above upper.
// - Snooze bit enables the snooze function when 1.
// - Resolution bit: 0 gives 10-bit result, 1 gives 8-bit result.
// - Separate writable 8-bit upper and lower limit registers bound the compare.
// - Channel code zero routes input 0; internal bit plus 00001 routes internal reference.
// - Done flag set on a window compare hit; set mask bit blocks the interrupt but not the flag.
`timescale 1ns/100ps
module acw_top
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // AXI4-Lite write
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Trigger sources and converted sample
    input  wire logic [3:0]  HW_TRIG,
    input  wire logic [9:0]  ANALOG_DATA,
    // Converter control
    output logic             CONV_RESET,
    output logic             CONV_CLK_EN,
    output logic             FAD_TICK,
    output logic             SAMPLING,
    output logic             CONV_BUSY,
    output logic [5:0]       CHANNEL_SEL,
    output logic [1:0]       POS_REF,
    output logic             NEG_REF,
    output logic             RES_8BIT,
    output logic             SNOOZE_EN,
    // Interrupt
    output logic             IRQ
);

    acw_pkg::acw_state_t q;
    acw_pkg::acw_state_t n;

    logic       tick;
    logic       armed;
    logic       last_tick;
    logic [4:0] total;
    logic [4:0] samp;
    logic [7:0] cmp_val;
    logic       hit;
    logic [7:0] set_bits;
    logic       hw_ev;

    always_comb
    begin
        n         = q;
        set_bits  = 8'h00;
        tick      = (q.div_cnt == 7'(acw_pkg::acw_div(q.m0.conv_clock_div) - 7'h01));
        armed     = q.m0.conversion_run && q.m0.comparator_enable;
        total     = (q.m0.conv_timing == acw_pkg::TIMING_LV2) ? acw_pkg::LV2_CLKS
                                                               : acw_pkg::LV1_CLKS;
        samp      = (q.m0.conv_timing == acw_pkg::TIMING_LV2) ? acw_pkg::LV2_SAMP
                                                               : acw_pkg::LV1_SAMP;
        last_tick = tick && (q.tick_cnt == 5'(total - 5'h01));
        // Trigger taken as a level; pulses during a conversion are lost
        hw_ev     = HW_TRIG[q.trg.hw_trigger_source];
        cmp_val   = ANALOG_DATA[9:2];
        if (q.refc.window_check_select)
            hit = (cmp_val < q.ll) || (cmp_val > q.ul);
        else
            hit = (q.ll <= cmp_val) && (cmp_val <= q.ul);

        // Converter sequencing, frozen while its clock is gated
        // Divider restarts on entry to each phase, so phases are whole converter clocks
        n.fad_tick = 1'b0;
        if (q.pclk[acw_pkg::CONV_CLKEN_BIT])
        begin
            if (q.st == acw_pkg::ST_STAB || q.st == acw_pkg::ST_CONV)
                n.div_cnt = tick ? 7'h00 : 7'(q.div_cnt + 7'h01);
            else
                n.div_cnt = 7'h00;
            n.fad_tick = tick && (q.st == acw_pkg::ST_STAB || q.st == acw_pkg::ST_CONV);
            if (!armed)
            begin
                n.st       = acw_pkg::ST_IDLE;
                n.tick_cnt = 5'h00;
                n.scan_idx = 2'h0;
            end
            else
            begin
                case (q.st)
                    acw_pkg::ST_IDLE:
                    begin
                        n.tick_cnt = 5'h00;
                        if (q.trg.trigger_mode[1])
                            n.st = acw_pkg::ST_WAIT;
                        else
                            n.st = acw_pkg::ST_STAB;
                    end
                    acw_pkg::ST_WAIT:
                    begin
                        n.tick_cnt = 5'h00;
                        if (!q.trg.trigger_mode[1])
                            n.st = acw_pkg::ST_IDLE;
                        else if (hw_ev)
                        begin
                            if (q.trg.trigger_mode == acw_pkg::TMODE_HW_NOWAIT)
                                n.st = acw_pkg::ST_CONV;
                            else
                                n.st = acw_pkg::ST_STAB;
                        end
                    end
                    acw_pkg::ST_STAB:
                    begin
                        if (tick)
                        begin
                            if (q.tick_cnt == 5'(acw_pkg::STAB_CLKS - 5'h01))
                            begin
                                n.tick_cnt = 5'h00;
                                n.st       = acw_pkg::ST_CONV;
                            end
                            else
                                n.tick_cnt = 5'(q.tick_cnt + 5'h01);
                        end
                    end
                    acw_pkg::ST_CONV:
                    begin
                        if (last_tick)
                        begin
                            n.tick_cnt = 5'h00;
                            if (q.refc.resolution_select)
                                n.result = {2'b00, ANALOG_DATA[9:2]};
                            else
                                n.result = ANALOG_DATA;
                            if (hit)
                                set_bits[acw_pkg::DONE_FLAG_BIT] = 1'b1;
                            if (q.m0.channel_select_mode)
                                n.scan_idx = 2'(q.scan_idx + 2'h1);
                            if (q.trg.oneshot_select)
                            begin
                                if (q.trg.trigger_mode[1])
                                    n.st = acw_pkg::ST_WAIT;
                                else
                                begin
                                    n.st                = acw_pkg::ST_IDLE;
                                    n.m0.conversion_run = 1'b0;
                                end
                            end
                            else
                                n.st = acw_pkg::ST_CONV;
                        end
                        else if (tick)
                            n.tick_cnt = 5'(q.tick_cnt + 5'h01);
                    end
                    default:
                        n.st = acw_pkg::ST_IDLE;
                endcase
            end
        end

        // AXI write channel capture
        if (AWVALID && q.awready)
        begin
            n.aw_v = 1'b1;
            n.aw_a = AWADDR;
        end
        if (WVALID && q.wready)
        begin
            n.w_v     = 1'b1;
            n.w_d     = WDATA[7:0];
            n.w_lane0 = WSTRB[0];
        end
        if (q.bvalid && BREADY)
            n.bvalid = 1'b0;
        if (q.aw_v && q.w_v && !q.bvalid)
        begin
            n.aw_v   = 1'b0;
            n.w_v    = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = acw_pkg::RESP_OKAY;
            case (q.aw_a)
                acw_pkg::OFF_PRST:
                    if (q.w_lane0) n.prst = q.w_d;
                acw_pkg::OFF_PCLK:
                    if (q.w_lane0) n.pclk = q.w_d;
                acw_pkg::OFF_MODE0:
                    if (q.w_lane0)
                    begin
                        n.m0 = acw_pkg::acw_mode0_t'(q.w_d);
                        // A clear of the run bit by hardware loses to a software start
                    end
                acw_pkg::OFF_TRIG:
                    if (q.w_lane0) n.trg = acw_pkg::acw_trig_t'(q.w_d & 8'hE3);
                acw_pkg::OFF_REFC:
                    if (q.w_lane0)
                    begin
                        n.refc = acw_pkg::acw_refc_t'(q.w_d & 8'hED);
                        if (q.w_d[7:6] == acw_pkg::PREF_PROHIBITED)
                            n.refc.pos_reference = q.refc.pos_reference;
                    end
                acw_pkg::OFF_UL:
                    if (q.w_lane0) n.ul = q.w_d;
                acw_pkg::OFF_LL:
                    if (q.w_lane0) n.ll = q.w_d;
                acw_pkg::OFF_CHSEL:
                    if (q.w_lane0) n.chs = acw_pkg::acw_chsel_t'(q.w_d & 8'h9F);
                acw_pkg::OFF_RESULT:
                    n.bresp = acw_pkg::RESP_OKAY;
                acw_pkg::OFF_STAT:
                    if (q.w_lane0) n.stat = q.stat & ~q.w_d;
                acw_pkg::OFF_MASK:
                    if (q.w_lane0) n.mask = q.w_d;
                default:
                    n.bresp = acw_pkg::RESP_SLVERR;
            endcase
        end
        // New events win over a same-cycle clear
        n.stat = n.stat | set_bits;

        // AXI read channel
        if (q.rvalid && RREADY)
            n.rvalid = 1'b0;
        if (ARVALID && q.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp  = acw_pkg::RESP_OKAY;
            case (ARADDR)
                acw_pkg::OFF_PRST:   n.rdata = {24'h000000, q.prst};
                acw_pkg::OFF_PCLK:   n.rdata = {24'h000000, q.pclk};
                acw_pkg::OFF_MODE0:  n.rdata = {24'h000000, q.m0};
                acw_pkg::OFF_TRIG:   n.rdata = {24'h000000, q.trg};
                acw_pkg::OFF_REFC:   n.rdata = {24'h000000, q.refc};
                acw_pkg::OFF_UL:     n.rdata = {24'h000000, q.ul};
                acw_pkg::OFF_LL:     n.rdata = {24'h000000, q.ll};
                acw_pkg::OFF_CHSEL:  n.rdata = {24'h000000, q.chs};
                acw_pkg::OFF_RESULT: n.rdata = {22'h000000, q.result};
                acw_pkg::OFF_STAT:   n.rdata = {24'h000000, q.stat};
                acw_pkg::OFF_MASK:   n.rdata = {24'h000000, q.mask};
                default:
                begin
                    n.rdata = 32'h00000000;
                    n.rresp = acw_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Converter held in reset with its registers at their reset values
        if (n.prst[acw_pkg::CONV_RESET_BIT])
        begin
            n.m0       = acw_pkg::acw_mode0_t'(acw_pkg::RST_ZERO8);
            n.trg      = acw_pkg::acw_trig_t'(acw_pkg::RST_ZERO8);
            n.refc     = acw_pkg::acw_refc_t'(acw_pkg::RST_ZERO8);
            n.chs      = acw_pkg::acw_chsel_t'(acw_pkg::RST_ZERO8);
            n.ul       = acw_pkg::RST_UL;
            n.ll       = acw_pkg::RST_LL;
            n.result   = 10'h000;
            n.st       = acw_pkg::ST_IDLE;
            n.div_cnt  = 7'h00;
            n.tick_cnt = 5'h00;
            n.scan_idx = 2'h0;
            n.fad_tick = 1'b0;
        end

        // Registered outputs
        n.awready  = !n.aw_v;
        n.wready   = !n.w_v;
        n.arready  = !n.rvalid;
        n.busy     = (n.st == acw_pkg::ST_STAB) || (n.st == acw_pkg::ST_CONV);
        n.sampling = (n.st == acw_pkg::ST_CONV) && (n.tick_cnt < samp);
        if (n.chs.internal_source_select)
            n.chan = {1'b1, n.chs.channel};
        else if (n.m0.channel_select_mode)
            n.chan = {1'b0, 5'(n.chs.channel + {3'b000, n.scan_idx})};
        else
            n.chan = {1'b0, n.chs.channel};
        // Level interrupt from the next status, so it rises with the flag
        n.irq = |(n.stat & ~n.mask);
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            q          <= '0;
            q.prst     <= acw_pkg::RST_PRST;
            q.pclk     <= acw_pkg::RST_PCLK;
            q.ul       <= acw_pkg::RST_UL;
            q.ll       <= acw_pkg::RST_LL;
            q.mask     <= acw_pkg::RST_MASK;
            q.st       <= acw_pkg::ST_IDLE;
            q.awready  <= 1'b1;
            q.wready   <= 1'b1;
            q.arready  <= 1'b1;
        end
        else
            q <= n;
    end

    assign AWREADY     = q.awready;
    assign WREADY      = q.wready;
    assign BVALID      = q.bvalid;
    assign BRESP       = q.bresp;
    assign ARREADY     = q.arready;
    assign RVALID      = q.rvalid;
    assign RDATA       = q.rdata;
    assign RRESP       = q.rresp;
    assign CONV_RESET  = q.prst[acw_pkg::CONV_RESET_BIT];
    assign CONV_CLK_EN = q.pclk[acw_pkg::CONV_CLKEN_BIT];
    assign FAD_TICK    = q.fad_tick;
    assign SAMPLING    = q.sampling;
    assign CONV_BUSY   = q.busy;
    assign CHANNEL_SEL = q.chan;
    assign POS_REF     = q.refc.pos_reference;
    assign NEG_REF     = q.refc.neg_reference_select;
    assign RES_8BIT    = q.refc.resolution_select;
    assign SNOOZE_EN   = q.refc.snooze_enable;
    assign IRQ         = q.irq;

endmodule

// ---- verif/acw_src.sv ----
// Model of the analog inputs and hardware trigger sources
`timescale 1ns/100ps
module acw_src
(
    // Bench control
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic [1:0] src,
    input  wire logic [9:0] level,
    input  wire logic       busy,
    // Toward the converter control
    output logic [3:0]      trig,
    output logic [9:0]      data
);
    always_ff @(posedge clk)
        trig <= fire ? 4'h1 << src : 4'h0;
    // Stale sample outside a conversion
    assign data = busy ? level : ~level;
endmodule

// ---- verif/acw_chk.sv ----
// Checker on the converter control top ports
`timescale 1ns/100ps
module acw_chk
(
    // Watched top ports
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [1:0]  BRESP,
    input wire logic [7:0]  ARADDR,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        CONV_RESET,
    input wire logic        CONV_CLK_EN,
    input wire logic        FAD_TICK,
    input wire logic        SAMPLING,
    input wire logic        CONV_BUSY
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    property p_rst;
        CONV_RESET && $past(CONV_RESET) |-> !CONV_BUSY && !FAD_TICK;
    endproperty
    a_rst: assert property (p_rst) else $error("converter active in reset");
    property p_gate;
        !CONV_CLK_EN && $past(!CONV_CLK_EN) |-> !FAD_TICK;
    endproperty
    a_gate: assert property (p_gate) else $error("tick while gated");
    property p_tick;
        FAD_TICK |=> !FAD_TICK;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too close");
    property p_samp;
        SAMPLING |-> CONV_BUSY;
    endproperty
    a_samp: assert property (p_samp) else $error("sampling while idle");
    property p_bhold;
        BVALID && !BREADY |=> BVALID && $stable(BRESP);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read response dropped");
    property p_ans;
        ARVALID && ARREADY |=> RVALID && !ARREADY;
    endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_unm;
        ARVALID && ARREADY && ARADDR >= 8'h2C && ARADDR[1:0] == 2'h0
            |=> RRESP == 2'h2 && RDATA == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not refused");
endmodule
bind acw_top acw_chk u_chk (.*);

// ---- verif/acw_tb_top.sv ----
// Randomised self-checking bench for the converter control block
`timescale 1ns/100ps
module acw_tb_top;
    logic        CLOCK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, IRQ;
    logic        ARVALID, ARREADY, RVALID, RREADY, CONV_RESET, CONV_CLK_EN, FAD_TICK;
    logic        SAMPLING, CONV_BUSY, NEG_REF, RES_8BIT, SNOOZE_EN, fire, wc, m, lv;
    logic [1:0]  BRESP, RRESP, POS_REF, src, r;
    logic [3:0]  WSTRB, HW_TRIG;
    logic [5:0]  CHANNEL_SEL;
    logic [7:0]  AWADDR, ARADDR, ul, ll, rf;
    logic [9:0]  ANALOG_DATA, lvl, v;
    logic [31:0] WDATA, RDATA, d;
    int          bad_count, n_tests, i, cyc;
    integer      seed;

    acw_top DUT (.*);
    acw_src u_src (.clk(CLOCK), .fire(fire), .src(src), .level(lvl), .busy(CONV_BUSY),
                   .trig(HW_TRIG), .data(ANALOG_DATA));

    initial
    begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    function automatic logic hit(input logic [9:0] x, input logic [7:0] u, l, input logic w);
        return w ^ (l <= x[9:2] && x[9:2] <= u);
    endfunction
    function automatic int dv(input int c);
        return c < 4 ? 64 >> c : c == 7 ? 2 : 10 - c;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        AWADDR <= a;
        WDATA <= {24'h0, x};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        do
        begin
            @(posedge CLOCK);
            aw = aw && !AWREADY;
            w = w && !WREADY;
            AWVALID <= aw;
            WVALID <= w;
        end
        while (aw || w);
        do
            @(posedge CLOCK);
        while (!BVALID);
        r = BRESP;
    endtask
    task automatic rd(input logic [7:0] a);
        ARADDR <= a;
        ARVALID <= 1'b1;
        do
            @(posedge CLOCK);
        while (!ARREADY);
        ARVALID <= 1'b0;
        do
            @(posedge CLOCK);
        while (!RVALID);
        d = RDATA;
        r = RRESP;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("read data", e, d);
        chk("read resp", acw_pkg::RESP_OKAY, r);
    endtask
    task automatic pulse(input logic [1:0] s);
        src <= s;
        fire <= 1'b1;
        @(posedge CLOCK);
        fire <= 1'b0;
    endtask
    task automatic meas;
        cyc = 0;
        do
        begin
            @(posedge CLOCK);
            cyc += CONV_BUSY;
        end
        while (cyc == 0 || CONV_BUSY);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        // Response ready held high so every answer is taken as it appears
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, fire} = 6'h0A;
        {AWADDR, ARADDR, WDATA, src, lvl} = 60'h0;
        WSTRB = 4'hF;
        seed = 32'h9CBB72EC;
        RST = 1'b1;
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        for (i = 0; i < 11; i++)
            rc(8'(i * 4), i == 5 ? 32'hFF : i == 10 ? 32'h1 : 32'h0);
        rd(8'h30);
        chk("unmapped resp", acw_pkg::RESP_SLVERR, r);
        wr(8'h30, 8'hFF);
        chk("unmapped write", acw_pkg::RESP_SLVERR, r);
        wr(acw_pkg::OFF_PCLK, 8'h20);
        chk("write resp", acw_pkg::RESP_OKAY, r);
        chk("clock gate", 1'b1, CONV_CLK_EN);
        $display("test registers done");
        for (i = 0; i < 8; i++)
        begin
            {lv, wc, m} = 3'($random(seed));
            {ul, ll, v} = 26'($random(seed));
            if (i < 2)
            begin
                ll = ul;
                v = {ul + 8'(i), 2'h3};
            end
            lvl <= v;
            rf = {2'(i % 3), i[1], 1'b0, wc, i[2], 1'b0, lv};
            wr(acw_pkg::OFF_UL, ul);
            wr(acw_pkg::OFF_LL, ll);
            // Comparator stopped before the reference changes
            wr(acw_pkg::OFF_MODE0, 8'h00);
            wr(acw_pkg::OFF_REFC, rf);
            if (rf[7:6] == 2'b10)
                repeat (200) @(posedge CLOCK);
            wr(acw_pkg::OFF_MASK, {7'h0, m});
            wr(acw_pkg::OFF_TRIG, {1'b0, i[0], 6'h20});
            chk("refs", {rf[7:5], rf[2], rf[0]}, {POS_REF, NEG_REF, SNOOZE_EN, RES_8BIT});
            wr(acw_pkg::OFF_MODE0, {2'b10, 3'(i), 1'b1, lv, 1'b1});
            meas;
            chk("busy cycles", dv(i) * (lv ? 19 : 21), cyc);
            rc(acw_pkg::OFF_MODE0, {3'b0, 3'(i), 1'b1, lv, 1'b1});
            rc(acw_pkg::OFF_RESULT, lv ? {2'b0, v[9:2]} : v);
            rc(acw_pkg::OFF_STAT, hit(v, ul, ll, wc));
            chk("irq", hit(v, ul, ll, wc) & !m, IRQ);
            wr(acw_pkg::OFF_STAT, 8'h01);
            chk("irq cleared", 1'b0, IRQ);
        end
        wr(acw_pkg::OFF_REFC, {2'b11, rf[5:0]});
        chk("forbidden ref", rf[7:6], POS_REF);
        $display("test software conversions done");
        for (i = 0; i < 4; i++)
        begin
            wr(acw_pkg::OFF_TRIG, {1'b1, i[0], 4'h8, 2'(i)});
            wr(acw_pkg::OFF_MODE0, 8'hBD);
            pulse(2'(i + 1));
            repeat (20) @(posedge CLOCK);
            chk("other source", 1'b0, CONV_BUSY);
            pulse(2'(i));
            meas;
            chk("hw cycles", i[0] ? 42 : 38, cyc);
            pulse(2'(i));
            meas;
            chk("second trigger", i[0] ? 42 : 38, cyc);
            wr(acw_pkg::OFF_MODE0, 8'h00);
        end
        $display("test hardware triggers done");
        wr(acw_pkg::OFF_TRIG, 8'h00);
        wr(acw_pkg::OFF_CHSEL, 8'h02);
        wr(acw_pkg::OFF_MODE0, 8'hFD);
        chk("scan first", 6'h02, CHANNEL_SEL);
        repeat (50) @(posedge CLOCK);
        chk("scan next", 6'h03, CHANNEL_SEL);
        chk("sequential", 1'b1, CONV_BUSY);
        wr(acw_pkg::OFF_MODE0, 8'h00);
        $display("test scan and sequential done");
        wr(acw_pkg::OFF_CHSEL, 8'h81);
        chk("channel", 6'h21, CHANNEL_SEL);
        wr(acw_pkg::OFF_PRST, 8'h20);
        chk("converter reset", 1'b1, CONV_RESET);
        rc(acw_pkg::OFF_CHSEL, 32'h0);
        wr(acw_pkg::OFF_PRST, 8'h00);
        $display("test reset and channel done");
        wrap_up;
    end

    initial
    begin
        #2000000;
        bad_count++;
        wrap_up;
    end
endmodule
